// >>> rtl/isp_pkg.sv
// Package with constants shared by the sensor port and the master end.
package isp_pkg;
	localparam int          CLK_HZ          = 100000000;
	localparam int          FRAME_BITS      = 16;
	localparam int          ADDR_BITS       = 7;
	localparam int          RATE_MILLI_SPS  = 819200;
	localparam int          SAMPLE_CYCLES   = int'((64'(CLK_HZ) * 1000) / RATE_MILLI_SPS);
	localparam int          BACKUP_MS       = 50;
	localparam int          BACKUP_CYCLES   = int'((64'(CLK_HZ) * BACKUP_MS) / 1000);
	localparam int          NORMAL_SCLK_HZ  = 2000000;
	localparam int          BURST_SCLK_HZ   = 1000000;
	localparam int          LOWPWR_SCLK_HZ  = 300000;
	localparam int          DRDY_CYCLES     = 4;
	localparam int          WORD_COUNT      = 64;
	localparam logic [6:0]  FLASH_WRITE_COUNTER_ADDR  = 7'h00;
	localparam logic [6:0]  OUT_FIRST_ADDR  = 7'h02;
	localparam logic [6:0]  OUT_LAST_ADDR   = 7'h16;
	localparam int          BURST_WORDS     = 11;
	localparam logic [6:0]  RW_FIRST_ADDR   = 7'h1A;
	localparam logic [6:0]  RW_LAST_ADDR    = 7'h3F;
	localparam logic [6:0]  GLOBAL_CMD_ADDR = 7'h3E;
	localparam int          BACKUP_BIT      = 3;
	localparam logic [15:0] BURST_FRAME     = 16'h3E00;
	localparam logic [15:0] BACKUP_FRAME    = 16'hBE08;
	localparam logic [15:0] SMPL_RESET      = 16'h0001;
	localparam logic [6:0]  SMPL_ADDR       = 7'h36;
	localparam logic [15:0] MSC_RESET       = 16'h0006;
	localparam logic [6:0]  MSC_ADDR        = 7'h34;
	localparam logic [15:0] AVG_RESET       = 16'h0402;
	localparam logic [6:0]  AVG_ADDR        = 7'h38;
endpackage : isp_pkg

// >>> rtl/isp_link_if.sv
// Interface carrying the four SPI wires and the data ready pin.
`timescale 1ns/1ps
interface isp_link_if;
	logic sclk;
	logic csN;
	logic mosi;
	logic miso;
	logic dataReadyPin;

	// Master drives clock, select and data in; sensor drives data out.
	modport sensor (input sclk, input csN, input mosi, output miso, output dataReadyPin);
	modport master (output sclk, output csN, output mosi, input miso, input dataReadyPin);
endinterface : isp_link_if

// >>> rtl/isp_sensor_port.sv
// Sensor end: autonomous sampling, register file and SPI slave port.
`timescale 1ns/1ps
module isp_sensor_port
	import isp_pkg::*;
#(
	parameter int SAMPLE_PERIOD = SAMPLE_CYCLES,
	parameter int BACKUP_TIME   = BACKUP_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	isp_link_if.sensor       link,
	input  wire logic [15:0] sampleWords [BURST_WORDS],
	output logic             backupBusy,
	output logic             sampleStrobe
);
	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} isp_slave_type;

	logic [2:0]  sclkSync_reg;
	logic [2:0]  csSync_reg;
	logic [2:0]  mosiSync_reg;
	logic        sclkStable_reg;
	logic        csStable_reg;
	logic [15:0] regs_reg [WORD_COUNT];
	logic [31:0] sampleCnt_reg;
	logic [31:0] backupCnt_reg;
	logic [2:0]  drdyCnt_reg;
	logic        drdy_reg;
	logic [15:0] shiftIn_reg;
	logic [15:0] shiftOut_reg;
	logic [4:0]  bitCnt_reg;
	logic        miso_reg;
	logic [15:0] readNext_reg;
	logic [3:0]  burstIdx_reg;
	logic        burstOn_reg;
	isp_slave_type state_reg;
	logic        sclkRise;
	logic        sclkFall;
	logic        frameEnd;
	logic [6:0]  rxAddr;
	logic        writeOk;

	// Pins pass three flops; a clock or select change counts once stages two and three agree.
	always_ff @(posedge core_clk) begin
		sclkSync_reg <= {sclkSync_reg[1:0], link.sclk};
		csSync_reg   <= {csSync_reg[1:0], link.csN};
		mosiSync_reg <= {mosiSync_reg[1:0], link.mosi};
		if (reset) begin
			sclkStable_reg <= 1'b1;
			csStable_reg   <= 1'b1;
		end else begin
			if (sclkSync_reg[1] == sclkSync_reg[2]) sclkStable_reg <= sclkSync_reg[2];
			if (csSync_reg[1] == csSync_reg[2]) csStable_reg <= csSync_reg[2];
		end
	end

	// Edge detection on the filtered clock, gated by an active select.
	always_comb begin
		sclkRise = (sclkSync_reg[1] == sclkSync_reg[2]) && sclkSync_reg[2] && !sclkStable_reg
			&& !csStable_reg;
		sclkFall = (sclkSync_reg[1] == sclkSync_reg[2]) && !sclkSync_reg[2] && sclkStable_reg
			&& !csStable_reg;
		frameEnd = (state_reg == ST_DONE);
		rxAddr   = shiftIn_reg[14:8];
		writeOk  = shiftIn_reg[15] && (rxAddr >= RW_FIRST_ADDR) && (rxAddr <= RW_LAST_ADDR);
	end

	always_ff @(posedge core_clk) begin
		if (reset || sampleCnt_reg >= 32'(SAMPLE_PERIOD - 1)) sampleCnt_reg <= '0;
		else sampleCnt_reg <= sampleCnt_reg + 32'h1;
	end

	// Data ready pulse after the output load.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			drdyCnt_reg  <= '0;
			drdy_reg     <= 1'b0;
			sampleStrobe <= 1'b0;
		end else begin
			sampleStrobe <= (sampleCnt_reg == 32'(SAMPLE_PERIOD - 1));
			if (sampleStrobe) begin
				drdyCnt_reg <= 3'(DRDY_CYCLES);
				drdy_reg    <= 1'b1;
			end else if (drdyCnt_reg != 3'h0) begin
				drdyCnt_reg <= drdyCnt_reg - 3'h1;
				drdy_reg    <= (drdyCnt_reg != 3'h1);
			end
		end
	end
	assign link.dataReadyPin = drdy_reg;

	// Register file: sample load, byte writes, flash counter.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < WORD_COUNT; i++) regs_reg[i] <= 16'h0000;
			regs_reg[SMPL_ADDR[6:1]] <= SMPL_RESET;
			regs_reg[MSC_ADDR[6:1]]  <= MSC_RESET;
			regs_reg[AVG_ADDR[6:1]]  <= AVG_RESET;
		end else begin
			if (sampleCnt_reg == 32'(SAMPLE_PERIOD - 1)) begin
				for (int i = 0; i < BURST_WORDS; i++)
					regs_reg[int'(OUT_FIRST_ADDR[6:1]) + i] <= sampleWords[i];
			end
			if (frameEnd && writeOk && rxAddr != GLOBAL_CMD_ADDR) begin
				if (rxAddr[0]) regs_reg[rxAddr[6:1]][15:8] <= shiftIn_reg[7:0];
				else regs_reg[rxAddr[6:1]][7:0] <= shiftIn_reg[7:0];
			end
			if (backupCnt_reg == 32'h1) regs_reg[FLASH_WRITE_COUNTER_ADDR[6:1]] <=
				regs_reg[FLASH_WRITE_COUNTER_ADDR[6:1]] + 16'h0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			backupCnt_reg <= '0;
			backupBusy    <= 1'b0;
		end else if (frameEnd && writeOk && rxAddr == GLOBAL_CMD_ADDR
				&& shiftIn_reg[BACKUP_BIT] && backupCnt_reg == 32'h0) begin
			backupCnt_reg <= 32'(BACKUP_TIME);
			backupBusy    <= 1'b1;
		end else if (backupCnt_reg != 32'h0) begin
			backupCnt_reg <= backupCnt_reg - 32'h1;
			backupBusy    <= (backupCnt_reg != 32'h1);
		end
	end

	// Slave frame engine in mode 3.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg    <= ST_IDLE;
			bitCnt_reg   <= '0;
			shiftIn_reg  <= '0;
			shiftOut_reg <= '0;
			miso_reg     <= 1'b1;
			readNext_reg <= '0;
			burstIdx_reg <= '0;
			burstOn_reg  <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (!csStable_reg) begin
						state_reg    <= ST_SHIFT;
						bitCnt_reg   <= '0;
						shiftOut_reg <= readNext_reg;
						miso_reg     <= readNext_reg[15];
					end
				end
				ST_SHIFT: begin
					if (sclkRise) begin
						shiftIn_reg <= {shiftIn_reg[14:0], mosiSync_reg[2]};
						bitCnt_reg  <= bitCnt_reg + 5'h1;
					end
					if (sclkFall && bitCnt_reg != 5'h0) begin
						shiftOut_reg <= {shiftOut_reg[14:0], 1'b0};
						miso_reg     <= shiftOut_reg[14];
					end
					if (csStable_reg || (bitCnt_reg == 5'(FRAME_BITS) && sclkFall))
						state_reg <= ST_DONE;
				end
				ST_DONE: begin
					state_reg <= csStable_reg ? ST_IDLE : ST_SHIFT;
					bitCnt_reg <= '0;
					if (bitCnt_reg == 5'(FRAME_BITS) && shiftIn_reg == BURST_FRAME) begin
						burstOn_reg  <= 1'b1;
						burstIdx_reg <= 4'h1;
						readNext_reg <= regs_reg[OUT_FIRST_ADDR[6:1]];
					end else if (burstOn_reg && burstIdx_reg < 4'(BURST_WORDS)) begin
						burstIdx_reg <= burstIdx_reg + 4'h1;
						readNext_reg <= regs_reg[6'(OUT_FIRST_ADDR[6:1]) + 6'(burstIdx_reg)];
					end else if (bitCnt_reg == 5'(FRAME_BITS) && !shiftIn_reg[15]) begin
						burstOn_reg  <= 1'b0;
						readNext_reg <= regs_reg[rxAddr[6:1]];
					end else begin
						burstOn_reg  <= 1'b0;
						readNext_reg <= 16'h0000;
					end
					if (!csStable_reg) begin
						shiftOut_reg <= readNext_reg;
						miso_reg     <= 1'b0;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
	assign link.miso = miso_reg;
endmodule : isp_sensor_port

// >>> rtl/isp_master_port.sv
// Master end: issues one 16-bit mode 3 frame per request.
`timescale 1ns/1ps
module isp_master_port
	import isp_pkg::*;
#(
	parameter int HALF_PERIOD = CLK_HZ / (2 * NORMAL_SCLK_HZ),
	parameter int GAP_CYCLES  = 1000
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	isp_link_if.master       link,
	input  wire logic        reqValid,
	input  wire logic [15:0] reqFrame,
	output logic             reqReady,
	output logic             rspValid,
	output logic [15:0]      rspFrame,
	output logic             dataReady
);
	typedef enum logic [1:0] {MS_IDLE, MS_LOW, MS_HIGH, MS_GAP} isp_master_type;

	isp_master_type state_reg;
	logic [15:0]    txShift_reg;
	logic [15:0]    rxShift_reg;
	logic [4:0]     bitCnt_reg;
	logic [15:0]    divCnt_reg;
	logic           sclk_reg;
	logic           cs_reg;
	logic [2:0]     misoSync_reg;
	logic [2:0]     drdySync_reg;

	// Three-flop capture of the sensor outputs.
	always_ff @(posedge core_clk) begin
		misoSync_reg <= {misoSync_reg[1:0], link.miso};
		drdySync_reg <= {drdySync_reg[1:0], link.dataReadyPin};
		if (reset) dataReady <= 1'b0;
		else if (drdySync_reg[1] == drdySync_reg[2]) dataReady <= drdySync_reg[2];
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg   <= MS_IDLE;
			sclk_reg    <= 1'b1;
			cs_reg      <= 1'b1;
			reqReady    <= 1'b0;
			rspValid    <= 1'b0;
			rspFrame    <= '0;
			txShift_reg <= '0;
			rxShift_reg <= '0;
			bitCnt_reg  <= '0;
			divCnt_reg  <= '0;
		end else begin
			rspValid <= 1'b0;
			// Ready stands as a level while idle, so a held request is always taken.
			reqReady <= (state_reg == MS_IDLE) && !(reqValid && reqReady);
			if (divCnt_reg != 16'h0) divCnt_reg <= divCnt_reg - 16'h1;
			unique case (state_reg)
				MS_IDLE: begin
					if (reqValid && reqReady) begin
						txShift_reg <= reqFrame;
						cs_reg      <= 1'b0;
						bitCnt_reg  <= '0;
						divCnt_reg  <= 16'(HALF_PERIOD);
						reqReady    <= 1'b0;
						state_reg   <= MS_HIGH;
					end
				end
				MS_HIGH: begin
					if (divCnt_reg == 16'h0) begin
						if (bitCnt_reg == 5'(FRAME_BITS)) begin
							cs_reg     <= 1'b1;
							rspFrame   <= rxShift_reg;
							rspValid   <= 1'b1;
							divCnt_reg <= 16'(GAP_CYCLES);
							state_reg  <= MS_GAP;
						end else begin
							sclk_reg   <= 1'b0;
							// The first bit already stands from the select edge.
							if (bitCnt_reg != 5'h0) txShift_reg <= {txShift_reg[14:0], 1'b0};
							divCnt_reg <= 16'(HALF_PERIOD);
							state_reg  <= MS_LOW;
						end
					end
				end
				MS_LOW: begin
					if (divCnt_reg == 16'h0) begin
						sclk_reg    <= 1'b1;
						rxShift_reg <= {rxShift_reg[14:0], misoSync_reg[2]};
						bitCnt_reg  <= bitCnt_reg + 5'h1;
						divCnt_reg  <= 16'(HALF_PERIOD);
						state_reg   <= MS_HIGH;
					end
				end
				MS_GAP: begin
					if (divCnt_reg == 16'h0) state_reg <= MS_IDLE;
				end
				default: state_reg <= MS_IDLE;
			endcase
		end
	end

	assign link.sclk = sclk_reg;
	assign link.csN  = cs_reg;
	assign link.mosi = txShift_reg[15];
endmodule : isp_master_port

// >>> bench/isp_link_chk.sv
// Concurrent checks on the wires between the two ends.
`timescale 1ns/1ps
module isp_link_chk #(
	parameter int SAMPLE_PERIOD = 300
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic csN,
	input wire logic mosi,
	input wire logic miso,
	input wire logic dataReadyPin
);
	int   edgeCnt_reg;
	int   gapCnt_reg;
	logic seen_reg;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// Counts rising clock edges inside the current frame.
	always_ff @(posedge core_clk) begin
		if (reset || $fell(csN))
			edgeCnt_reg <= 0;
		else if (!csN && $rose(sclk))
			edgeCnt_reg <= edgeCnt_reg + 1;
	end
	// Counts cycles since the last data ready rise; the first rise only arms it.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			gapCnt_reg <= 0;
			seen_reg   <= 1'b0;
		end else if ($rose(dataReadyPin)) begin
			gapCnt_reg <= 1;
			seen_reg   <= 1'b1;
		end else
			gapCnt_reg <= gapCnt_reg + 1;
	end
	a_idle_clock_high: assert property (csN |-> sclk)
		else $error("clock low outside a frame");
	a_frame_end_high: assert property ($rose(csN) |-> sclk)
		else $error("frame ended with clock low");
	a_frame_sixteen: assert property ($rose(csN) |-> edgeCnt_reg == 16)
		else $error("frame without sixteen clock rises");
	a_miso_holds_high: assert property ($rose(sclk) && !csN |-> ##1 $stable(miso) [*8])
		else $error("data out moved while clock high");
	a_mosi_holds_high: assert property ($rose(sclk) && !csN |-> $stable(mosi) ##1 $stable(mosi) [*8])
		else $error("data in moved around the sampling edge");
	a_half_period_min: assert property ($changed(sclk) |=> $stable(sclk) [*3])
		else $error("clock half period too short");
	a_ready_pulse_len: assert property ($rose(dataReadyPin) |-> dataReadyPin [*4] ##1 !dataReadyPin)
		else $error("data ready pulse length wrong");
	a_sample_rate: assert property ($rose(dataReadyPin) && seen_reg |-> gapCnt_reg == SAMPLE_PERIOD)
		else $error("sample period wrong");
	c_frame_done: cover property ($rose(csN));
	c_ready_seen: cover property ($rose(dataReadyPin));
	c_two_frames: cover property ($rose(csN) ##[1:300] $fell(csN));
endmodule // isp_link_chk

// >>> bench/inertial_sensor_spi_register_port_tb_top.sv
// Self-checking bench joining the master end to the sensor end.
`timescale 1ns/1ps
module inertial_sensor_spi_register_port_tb_top import isp_pkg::*; ;
	localparam int SP = 300;
	localparam int BT = 50;
	logic        core_clk, reset, reqValid, reqReady, rspValid, dataReady, backupBusy, sampleStrobe;
	logic [15:0] reqFrame, rspFrame, sentFrame, mosiSh, misoSh, r, c0, d;
	logic [15:0] sw [BURST_WORDS];
	logic [6:0]  a;
	int          k, n_mismatch, n_tests;
	isp_link_if link ();
	isp_sensor_port #(.SAMPLE_PERIOD(SP), .BACKUP_TIME(BT)) isp_sensor_port_i (
		.core_clk(core_clk), .reset(reset), .link(link.sensor), .sampleWords(sw),
		.backupBusy(backupBusy), .sampleStrobe(sampleStrobe));
	isp_master_port #(.HALF_PERIOD(9), .GAP_CYCLES(20)) isp_master_port_i (
		.core_clk(core_clk), .reset(reset), .link(link.master), .reqValid(reqValid),
		.reqFrame(reqFrame), .reqReady(reqReady), .rspValid(rspValid),
		.rspFrame(rspFrame), .dataReady(dataReady));
	isp_link_chk #(.SAMPLE_PERIOD(SP)) isp_link_chk_i (
		.core_clk(core_clk), .reset(reset), .sclk(link.sclk), .csN(link.csN),
		.mosi(link.mosi), .miso(link.miso), .dataReadyPin(link.dataReadyPin));
	// Free-running core clock.
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic waitHi(ref logic s, input int lim);
		k = 0;
		while (s !== 1'b1 && k < lim) begin
			@(posedge core_clk);
			k++;
		end
	endtask
	// One frame: wait for ready, offer it for one edge, then collect the answer.
	task automatic xfer(input logic [15:0] f, output logic [15:0] rsp);
		waitHi(reqReady, 500);
		reqValid  <= 1'b1;
		reqFrame  <= f;
		sentFrame <= f;
		@(posedge core_clk);
		reqValid <= 1'b0;
		waitHi(rspValid, 500);
		rsp = rspFrame;
		chk(misoSh, rsp);
	endtask
	task automatic rdchk(input logic [6:0] ad, input logic [15:0] exp);
		xfer({1'b0, ad, 8'h00}, r);
		xfer(16'h0000, r);
		chk(r, exp);
	endtask
	task automatic wr(input logic [6:0] ad, input logic [7:0] b);
		xfer({1'b1, ad, b}, r);
	endtask
	// Both data wires are shifted on each rising clock edge inside a frame.
	always @(posedge link.sclk) begin
		if (link.csN === 1'b0) begin
			mosiSh <= {mosiSh[14:0], link.mosi};
			misoSh <= {misoSh[14:0], link.miso};
		end
	end
	// At frame end the data in wire must have carried the sent frame.
	always @(posedge link.csN) if (!reset) chk(mosiSh, sentFrame);
	// Watchdog against a hung handshake.
	initial begin
		repeat (60000) @(posedge core_clk);
		n_mismatch++;
		complete_run();
	end
	initial begin
		reset    = 1'b1;
		reqValid = 1'b0;
		reqFrame = 16'h0000;
		foreach (sw[i]) sw[i] = 16'h0000;
		void'($urandom(33));
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		// Configuration words come out of reset with their defaults.
		rdchk(MSC_ADDR, MSC_RESET);
		rdchk(SMPL_ADDR, SMPL_RESET);
		rdchk(AVG_ADDR, AVG_RESET);
		// New samples load, then data ready follows.
		foreach (sw[i]) sw[i] <= 16'($urandom);
		@(posedge core_clk);
		while (sampleStrobe === 1'b1) @(posedge core_clk);
		waitHi(sampleStrobe, 2 * SP);
		waitHi(dataReady, 20);
		chk(16'(k < 20), 16'h0001);
		// Burst returns every output word in address order.
		xfer(BURST_FRAME, r);
		foreach (sw[i]) begin
			xfer(16'h0000, r);
			chk(r, sw[i]);
		end
		// Two byte writes land in the low and high halves of one word.
		repeat (3) begin
			a = 7'h1A + 7'(2 * ($urandom % 13));
			d = 16'($urandom);
			wr(a, d[7:0]);
			wr(a + 7'h01, d[15:8]);
			rdchk(a, d);
		end
		// Back-to-back reads, each answered in the next frame.
		xfer({1'b0, AVG_ADDR, 8'h00}, r);
		xfer({1'b0, a, 8'h00}, r);
		chk(r, AVG_RESET);
		xfer(16'h0000, r);
		chk(r, d);
		// Writes to read-only and reserved places change nothing.
		xfer({1'b0, FLASH_WRITE_COUNTER_ADDR, 8'h00}, r);
		xfer(16'h0000, c0);
		wr(FLASH_WRITE_COUNTER_ADDR, 8'hA5);
		wr(OUT_FIRST_ADDR, 8'h5A);
		wr(7'h18, 8'h3C);
		rdchk(FLASH_WRITE_COUNTER_ADDR, c0);
		rdchk(OUT_FIRST_ADDR, sw[0]);
		rdchk(7'h18, 16'h0000);
		// Backup runs for its set time and bumps the write counter.
		xfer(BACKUP_FRAME, r);
		repeat (8) @(posedge core_clk);
		chk(16'(backupBusy), 16'h0001);
		k = 0;
		while (backupBusy !== 1'b0 && k < 2 * BT) begin
			@(posedge core_clk);
			k++;
		end
		chk(16'(k >= BT - 12 && k <= BT), 16'h0001);
		rdchk(FLASH_WRITE_COUNTER_ADDR, c0 + 16'h0001);
		complete_run();
	end
endmodule // inertial_sensor_spi_register_port_tb_top
